// file: logic/ppsc_pkg.sv
package ppsc_pkg;
  localparam int unsigned CLK_MHZ            = 100;
  localparam int unsigned SLEEP_RQST_TIME_US = 1000;
  localparam int unsigned SILENT_TIME_US     = 8000;
  localparam int unsigned SLEEP_RQST_CYCLES  = SLEEP_RQST_TIME_US * CLK_MHZ;
  localparam int unsigned SILENT_CYCLES      = SILENT_TIME_US * CLK_MHZ;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  localparam logic [15:0] OFS_RESET_CTRL = 16'h001F;
  localparam logic [15:0] OFS_AUTO_CTRL  = 16'h018B;
  localparam logic [15:0] OFS_PWR_MODE   = 16'h018C;
  localparam logic [15:0] OFS_STATE_STAT = 16'h018D;
  localparam logic [15:0] OFS_LOW_POWER_SLEEP_CONFIG    = 16'h04E5;

  localparam int unsigned BIT_SOFT_RESET   = 15;
  localparam int unsigned BIT_AUTO_EN      = 6;
  localparam int unsigned BIT_SLEEP_EN     = 1;
  localparam int unsigned BIT_LPS_TX_EN    = 0;
  localparam int unsigned BIT_FORCE_NORMAL = 0;
  localparam int unsigned BIT_SLEEP_REQ    = 1;
  localparam int unsigned BIT_SDN_LO       = 8;
  localparam int unsigned BIT_SDN_HI       = 9;
  localparam int unsigned BIT_STAT_LPS_RX  = 4;
  localparam int unsigned BIT_STAT_MASTER  = 5;

  localparam logic [1:0] SDN1_SEL      = 2'h3;
  localparam logic [1:0] SDN_SEL_RST   = 2'h0;
  localparam logic       SLEEP_EN_RST  = 1'h1;
  localparam logic       LPS_TX_EN_RST = 1'h0;

  typedef enum logic [2:0] {
    ST_POWER_DOWN = 3'h0,
    ST_RESET      = 3'h1,
    ST_STANDBY    = 3'h3,
    ST_NORMAL     = 3'h2,
    ST_SLEEP_REQ  = 3'h6,
    ST_SILENT     = 3'h7,
    ST_SLEEP      = 3'h5,
    ST_DISABLE    = 3'h4
  } ppsc_state_t;
endpackage

// file: logic/ppsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ppsc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // ppsc_sync
`default_nettype wire

// file: logic/ppsc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ppsc_timer #(
  parameter int unsigned COUNT = 2
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic start,
  input  wire logic run,
  output logic      expired
);
  localparam int unsigned CW = $clog2(COUNT);

  logic [CW-1:0] cnt;

  if (COUNT < 2)
  begin : g_chk
    $error("timer count must be at least 2");
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      cnt <= '0;
    else if (start)
      cnt <= CW'(COUNT - 1);
    else if (run && cnt != '0)
      cnt <= cnt - 1'b1;
  end

  assign expired = run && !start && cnt == '0;
endmodule // ppsc_timer
`default_nettype wire

// file: logic/ppsc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ppsc_ctrl
  import ppsc_pkg::*;
#(
  parameter int unsigned SLEEP_RQST_CYC = SLEEP_RQST_CYCLES,
  parameter int unsigned SILENT_CYC     = SILENT_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              analog_supply_good,
  input  wire logic              reset_pin_n,
  input  wire logic              enable_pin,
  input  wire logic              wake_pin,
  input  wire logic              strap_master,
  input  wire logic              strap_autonomous,
  input  wire logic              mdi_energy,
  input  wire logic              mdi_frame,
  input  wire logic              mac_frame,
  input  wire logic              mdi_quiet,
  input  wire logic              lps_rx,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_we,
  input  wire logic              reg_re,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic      [2:0]        state_code,
  output logic                   io_enable,
  output logic                   analog_enable,
  output logic                   energy_detect_enable,
  output logic                   termination_enable,
  output logic                   pcs_pma_enable,
  output logic                   smi_available,
  output logic                   tx_lps,
  output logic                   tx_send_z,
  output logic                   master_mode,
  output logic                   lps_received_flag
);
  ppsc_state_t state;
  ppsc_state_t next_state;
  logic [5:0]  pins_s;
  logic        supply_s;
  logic        rst_pin_s;
  logic        en_s;
  logic        wake_s;
  logic        strap_master_s;
  logic        strap_auto_s;
  logic        auto_en;
  logic        sleep_en;
  logic        lps_tx_en;
  logic [1:0]  sdn_sel;
  logic        wr;
  logic        soft_req;
  logic        force_normal_req;
  logic        sleep_req_req;
  logic        stat_read;
  logic        reg_clear;
  logic        reset_exit;
  logic        sreq_expired;
  logic        silent_expired;
  logic [DATA_W-1:0] next_rdata;

  if (SLEEP_RQST_CYC < 2 || SILENT_CYC < 2)
  begin : g_chk
    $error("timer counts must be at least 2");
  end

  // pins arrive asynchronously
  ppsc_sync #(.W(6)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({analog_supply_good, reset_pin_n, enable_pin,
            wake_pin, strap_master, strap_autonomous}),
    .q    (pins_s)
  );
  assign {supply_s, rst_pin_s, en_s, wake_s, strap_master_s, strap_auto_s} = pins_s;

  // management is dead while powered down, in reset, disabled or asleep
  assign smi_available = state inside {ST_STANDBY, ST_NORMAL, ST_SLEEP_REQ, ST_SILENT};
  assign wr               = reg_we && smi_available;
  assign soft_req         = wr && reg_addr == OFS_RESET_CTRL && reg_wdata[BIT_SOFT_RESET];
  assign force_normal_req = wr && reg_addr == OFS_PWR_MODE && reg_wdata[BIT_FORCE_NORMAL];
  assign sleep_req_req    = wr && reg_addr == OFS_PWR_MODE && reg_wdata[BIT_SLEEP_REQ];
  assign stat_read        = reg_re && smi_available && reg_addr == OFS_STATE_STAT;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_POWER_DOWN: next_state = ST_RESET;
      ST_RESET:
      begin
        if (!en_s)
          next_state = ST_DISABLE;
        else if (strap_auto_s)
          next_state = ST_NORMAL;
        else if (strap_master_s)
          next_state = ST_STANDBY;
        else
          next_state = ST_NORMAL;
      end
      ST_DISABLE:
      begin
        if (en_s)
          next_state = ST_RESET;
      end
      ST_STANDBY:
      begin
        if (mdi_energy)
          next_state = ST_NORMAL;
        else if (auto_en)
          next_state = ST_NORMAL;
        else if (force_normal_req)
          next_state = ST_NORMAL;
      end
      ST_NORMAL:
      begin
        // no path to standby from here
        if (sleep_req_req || lps_rx)
          next_state = ST_SLEEP_REQ;
      end
      ST_SLEEP_REQ:
      begin
        if (force_normal_req || mdi_frame || mac_frame)
          next_state = ST_NORMAL;
        else if (sreq_expired)
          next_state = ST_SILENT;
        else if (mdi_quiet)
          next_state = ST_SILENT;
      end
      ST_SILENT:
      begin
        if (mdi_energy)
          next_state = ST_STANDBY;
        else if (silent_expired)
          next_state = sleep_en ? ST_SLEEP : ST_STANDBY;
      end
      ST_SLEEP:
      begin
        // registers are gone, so waking rebuilds them through reset
        if (mdi_energy || wake_s)
          next_state = ST_RESET;
      end
    endcase
    if (!en_s && state inside {ST_STANDBY, ST_NORMAL, ST_SLEEP_REQ, ST_SILENT, ST_SLEEP})
      next_state = ST_DISABLE;
    if (!rst_pin_s || soft_req)
      next_state = ST_RESET;
    if (!supply_s)
      next_state = ST_POWER_DOWN;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      state <= ST_POWER_DOWN;
    else
      state <= next_state;
  end

  // timers restart on each entry
  ppsc_timer #(.COUNT(SLEEP_RQST_CYC)) u_sreq_timer (
    .clk     (clk),
    .nrst    (nrst),
    .start   (next_state == ST_SLEEP_REQ && state != ST_SLEEP_REQ),
    .run     (state == ST_SLEEP_REQ),
    .expired (sreq_expired)
  );

  ppsc_timer #(.COUNT(SILENT_CYC)) u_silent_timer (
    .clk     (clk),
    .nrst    (nrst),
    .start   (next_state == ST_SILENT && state != ST_SILENT),
    .run     (state == ST_SILENT),
    .expired (silent_expired)
  );

  assign reg_clear  = state inside {ST_POWER_DOWN, ST_RESET, ST_DISABLE, ST_SLEEP};
  assign reset_exit = state == ST_RESET && next_state != ST_RESET;

  // configuration registers; strap fields reload as reset ends
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      auto_en     <= 1'b0;
      sleep_en    <= SLEEP_EN_RST;
      lps_tx_en   <= LPS_TX_EN_RST;
      sdn_sel     <= SDN_SEL_RST;
      master_mode <= 1'b0;
    end
    else if (reset_exit)
    begin
      auto_en     <= strap_auto_s;
      master_mode <= strap_master_s;
      sleep_en    <= SLEEP_EN_RST;
      lps_tx_en   <= LPS_TX_EN_RST;
      sdn_sel     <= SDN_SEL_RST;
    end
    else if (reg_clear)
    begin
      auto_en     <= 1'b0;
      sleep_en    <= SLEEP_EN_RST;
      lps_tx_en   <= LPS_TX_EN_RST;
      sdn_sel     <= SDN_SEL_RST;
      master_mode <= 1'b0;
    end
    else if (wr && reg_addr == OFS_AUTO_CTRL)
    begin
      auto_en   <= reg_wdata[BIT_AUTO_EN];
      sleep_en  <= reg_wdata[BIT_SLEEP_EN];
      lps_tx_en <= reg_wdata[BIT_LPS_TX_EN];
    end
    else if (wr && reg_addr == OFS_LOW_POWER_SLEEP_CONFIG)
      sdn_sel <= reg_wdata[BIT_SDN_HI:BIT_SDN_LO];
  end

  // sticky; a new code-group beats a clearing read
  always_ff @(posedge clk)
  begin
    if (!nrst)
      lps_received_flag <= 1'b0;
    else if (reg_clear)
      lps_received_flag <= 1'b0;
    else if (lps_rx && state inside {ST_NORMAL, ST_SLEEP_REQ})
      lps_received_flag <= 1'b1;
    else if (stat_read)
      lps_received_flag <= 1'b0;
  end

  always_comb
  begin
    next_rdata = '0;
    if (smi_available)
    begin
      unique case (reg_addr)
        OFS_AUTO_CTRL:
        begin
          next_rdata[BIT_AUTO_EN]   = auto_en;
          next_rdata[BIT_SLEEP_EN]  = sleep_en;
          next_rdata[BIT_LPS_TX_EN] = lps_tx_en;
        end
        OFS_LOW_POWER_SLEEP_CONFIG:
          next_rdata[BIT_SDN_HI:BIT_SDN_LO] = sdn_sel;
        OFS_STATE_STAT:
        begin
          next_rdata[2:0]             = state;
          next_rdata[BIT_STAT_LPS_RX] = lps_received_flag;
          next_rdata[BIT_STAT_MASTER] = master_mode;
        end
        default:
          next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      reg_rdata <= '0;
    else if (reg_re)
      reg_rdata <= next_rdata;
  end

  assign state_code           = state;
  assign io_enable            = !(state inside {ST_POWER_DOWN, ST_DISABLE});
  assign analog_enable        = state inside {ST_STANDBY, ST_NORMAL, ST_SLEEP_REQ, ST_SILENT};
  assign energy_detect_enable = state inside {ST_STANDBY, ST_NORMAL, ST_SLEEP_REQ, ST_SILENT, ST_SLEEP};
  assign termination_enable   = state inside {ST_STANDBY, ST_NORMAL, ST_SLEEP_REQ, ST_SILENT};
  assign pcs_pma_enable       = state inside {ST_NORMAL, ST_SLEEP_REQ, ST_SILENT};
  // holding back until the sleep stream is chosen avoids a garbled request
  assign tx_lps = state == ST_SLEEP_REQ && lps_tx_en && sdn_sel == SDN1_SEL;
  assign tx_send_z = state == ST_SILENT;

  // checks
  logic        run_ok;
  logic [31:0] sreq_age;

  assign run_ok = supply_s && rst_pin_s && en_s && !soft_req;

  always_ff @(posedge clk)
  begin
    if (!nrst || state != ST_SLEEP_REQ)
      sreq_age <= '0;
    else
      sreq_age <= sreq_age + 32'h0000_0001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_sleeping_woken;
    state == ST_SLEEP && (mdi_energy || wake_s) && run_ok;
  endsequence

  sequence s_standby_kicked;
    state == ST_STANDBY && (mdi_energy || force_normal_req) && run_ok;
  endsequence

  power_down_a: assert property (!supply_s |=> state == ST_POWER_DOWN && !io_enable && !termination_enable)
    else $error("low supply did not power down");
  disable_off_a: assert property (state == ST_DISABLE
    |-> !io_enable && !termination_enable && !analog_enable)
    else $error("disabled state drives outputs");
  // reset lasts a single cycle when enabled, so only the entry cycle is pinned down
  soft_reset_a: assert property (soft_req && supply_s |=> state == ST_RESET && !smi_available)
    else $error("soft reset not taken");
  strap_load_a: assert property (reset_exit && !soft_req |=> auto_en == $past(strap_auto_s))
    else $error("strap not reloaded");
  standby_exit_a: assert property (s_standby_kicked |=> state == ST_NORMAL ##0 pcs_pma_enable)
    else $error("standby did not leave for normal");
  no_back_a: assert property (state == ST_NORMAL |=> state != ST_STANDBY)
    else $error("normal went to standby");
  lps_gate_a: assert property (tx_lps |-> state == ST_SLEEP_REQ && lps_tx_en)
    else $error("sleep code-groups sent outside request");
  sreq_bound_a: assert property (sreq_age <= SLEEP_RQST_CYC)
    else $error("sleep request outlived its timer");
  sreq_frame_a: assert property (state == ST_SLEEP_REQ && (mdi_frame || mac_frame) && run_ok
    |=> state == ST_NORMAL)
    else $error("frame did not cancel sleep request");
  silent_zero_a: assert property (state == ST_SILENT |-> tx_send_z && !tx_lps)
    else $error("silent state not sending zeros");
  silent_energy_a: assert property (state == ST_SILENT && mdi_energy && run_ok |=> state == ST_STANDBY)
    else $error("energy in silent did not reach standby");
  sleep_smi_a: assert property (state == ST_SLEEP |-> !smi_available ##1 sdn_sel == SDN_SEL_RST && !lps_received_flag)
    else $error("management reachable in sleep");
  wake_a: assert property (s_sleeping_woken |=> state == ST_RESET ##1 state != ST_SLEEP)
    else $error("wake ignored in sleep");
endmodule // ppsc_ctrl
`default_nettype wire

// file: testbench/ppsc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ppsc_partner (
  input  wire logic clk,
  input  wire logic tx_lps,
  input  wire logic energy_cmd,
  input  wire logic frame_cmd,
  input  wire logic lps_cmd,
  input  wire logic follow_cmd,
  output logic      mdi_energy,
  output logic      mdi_frame,
  output logic      lps_rx,
  output logic      mdi_quiet
);
  int unsigned lps_seen;

  // a partner that follows our sleep request goes quiet after a few code-groups
  always @(negedge clk)
  begin
    mdi_energy <= energy_cmd;
    mdi_frame  <= frame_cmd;
    lps_rx     <= lps_cmd;
    lps_seen   <= (tx_lps && follow_cmd) ? lps_seen + 1 : 0;
    mdi_quiet  <= follow_cmd && (lps_seen >= 2);
  end
endmodule // ppsc_partner
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ppsc_pkg::*;
;
  logic        clk, nrst, supply, rst_pin_n, en, wake, s_master, s_auto, mac_frame;
  logic        e_cmd, f_cmd, l_cmd, fol_cmd, we, re;
  logic [15:0] addr, wdata, rdata;
  logic [2:0]  state_code;
  logic        io_en, an_en, ed_en, term_en, pcs_en, smi_en, tx_lps, tx_z, master, flag;
  logic        mdi_energy, mdi_frame, mdi_quiet, lps_rx;
  logic [15:0] st, en6;
  int          n_fail, total_checks, n;

  assign st  = {13'h0000, state_code};
  assign en6 = {10'h000, io_en, an_en, ed_en, term_en, pcs_en, smi_en};

  ppsc_ctrl #(.SLEEP_RQST_CYC(8), .SILENT_CYC(16)) i_ppsc_ctrl (
    .clk(clk), .nrst(nrst), .analog_supply_good(supply), .reset_pin_n(rst_pin_n), .enable_pin(en),
    .wake_pin(wake), .strap_master(s_master), .strap_autonomous(s_auto), .mdi_energy(mdi_energy),
    .mdi_frame(mdi_frame), .mac_frame(mac_frame), .mdi_quiet(mdi_quiet), .lps_rx(lps_rx),
    .reg_addr(addr), .reg_wdata(wdata), .reg_we(we), .reg_re(re), .reg_rdata(rdata),
    .state_code(state_code), .io_enable(io_en), .analog_enable(an_en), .energy_detect_enable(ed_en),
    .termination_enable(term_en), .pcs_pma_enable(pcs_en), .smi_available(smi_en), .tx_lps(tx_lps),
    .tx_send_z(tx_z), .master_mode(master), .lps_received_flag(flag));

  ppsc_partner i_ppsc_partner (
    .clk(clk), .tx_lps(tx_lps), .energy_cmd(e_cmd), .frame_cmd(f_cmd), .lps_cmd(l_cmd),
    .follow_cmd(fol_cmd), .mdi_energy(mdi_energy), .mdi_frame(mdi_frame), .lps_rx(lps_rx),
    .mdi_quiet(mdi_quiet));

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [15:0] a, input logic [15:0] v);
    @(negedge clk);
    addr  <= a;
    wdata <= v;
    we    <= 1'b1;
    @(negedge clk);
    we    <= 1'b0;
  endtask

  task rd(input logic [15:0] a, input logic [15:0] exp);
    @(negedge clk);
    addr <= a;
    re   <= 1'b1;
    @(negedge clk);
    re   <= 1'b0;
    chk("reg read", rdata, exp);
  endtask

  // bounded wait, then the state itself is compared; n gives the cycles taken
  task ws(input logic [2:0] s, input int lim);
    n = 0;
    while (state_code !== s && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk("state", st, {13'h0000, s});
  endtask

  task results();
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #100000;
    n_fail++;
    results();
  end

  initial
  begin
    n_fail = 0;
    total_checks = 0;
    nrst = 1'b0;
    supply = 1'b1;
    rst_pin_n = 1'b1;
    en = 1'b1;
    wake = 1'b0;
    s_master = 1'b1;
    s_auto = 1'b0;
    mac_frame = 1'b0;
    e_cmd = 1'b0;
    f_cmd = 1'b0;
    l_cmd = 1'b0;
    fol_cmd = 1'b0;
    we = 1'b0;
    re = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    repeat (8) @(negedge clk);
    chk("reset state", st, 16'h0000);
    chk("reset enables", en6, 16'h0000);
    nrst <= 1'b1;
    ws(ST_STANDBY, 20);
    chk("standby enables", en6, 16'h003D);
    chk("master strap", {15'h0000, master}, 16'h0001);
    rd(OFS_STATE_STAT, 16'h0023);
    rd(OFS_AUTO_CTRL, 16'h0002);
    rd(16'h0100, 16'h0000);
    wr(OFS_LOW_POWER_SLEEP_CONFIG, 16'h0300);
    rd(OFS_LOW_POWER_SLEEP_CONFIG, 16'h0300);
    wr(OFS_PWR_MODE, 16'h0001);
    ws(ST_NORMAL, 0);
    chk("normal enables", en6, 16'h003F);
    rd(OFS_PWR_MODE, 16'h0000);
    e_cmd <= 1'b1;
    repeat (6) @(negedge clk);
    e_cmd <= 1'b0;
    ws(ST_NORMAL, 0);
    wr(OFS_AUTO_CTRL, 16'h0003);
    wr(OFS_PWR_MODE, 16'h0002);
    ws(ST_SLEEP_REQ, 0);
    chk("tx lps", {14'h0000, tx_lps, tx_z}, 16'h0002);
    ws(ST_SILENT, 40);
    chk("request cycles", n[15:0], 16'h0008);
    chk("send zero", {14'h0000, tx_lps, tx_z}, 16'h0001);
    ws(ST_SLEEP, 40);
    chk("silent cycles", n[15:0], 16'h0010);
    chk("sleep enables", en6 & 16'h000F, 16'h0008);
    rd(OFS_STATE_STAT, 16'h0000);
    @(negedge clk);
    wake <= 1'b1;
    ws(ST_STANDBY, 20);
    wake <= 1'b0;
    rd(OFS_LOW_POWER_SLEEP_CONFIG, 16'h0000);
    e_cmd <= 1'b1;
    ws(ST_NORMAL, 5);
    e_cmd <= 1'b0;
    @(negedge clk);
    l_cmd <= 1'b1;
    @(negedge clk);
    l_cmd <= 1'b0;
    ws(ST_SLEEP_REQ, 3);
    chk("flag", {15'h0000, flag}, 16'h0001);
    chk("lps blocked", {15'h0000, tx_lps}, 16'h0000);
    rd(OFS_STATE_STAT, 16'h0036);
    f_cmd <= 1'b1;
    @(negedge clk);
    f_cmd <= 1'b0;
    ws(ST_NORMAL, 3);
    // partner follows the request and falls quiet before the timer
    fol_cmd <= 1'b1;
    wr(OFS_LOW_POWER_SLEEP_CONFIG, 16'h0300);
    wr(OFS_AUTO_CTRL, 16'h0001);
    wr(OFS_PWR_MODE, 16'h0002);
    ws(ST_SILENT, 10);
    chk("quiet cycles", n[15:0], 16'h0003);
    fol_cmd <= 1'b0;
    ws(ST_STANDBY, 40);
    chk("no sleep cycles", n[15:0], 16'h0010);
    wr(OFS_PWR_MODE, 16'h0001);
    wr(OFS_PWR_MODE, 16'h0002);
    @(negedge clk);
    mac_frame <= 1'b1;
    @(negedge clk);
    mac_frame <= 1'b0;
    ws(ST_NORMAL, 1);
    wr(OFS_PWR_MODE, 16'h0002);
    ws(ST_SILENT, 40);
    // one-cycle energy, so standby is not left again before the autonomous bit
    e_cmd <= 1'b1;
    @(negedge clk);
    e_cmd <= 1'b0;
    ws(ST_STANDBY, 3);
    wr(OFS_AUTO_CTRL, 16'h0040);
    ws(ST_NORMAL, 2);
    en <= 1'b0;
    ws(ST_DISABLE, 10);
    chk("disable enables", en6, 16'h0000);
    en <= 1'b1;
    ws(ST_STANDBY, 20);
    wr(OFS_RESET_CTRL, 16'h8000);
    ws(ST_RESET, 2);
    ws(ST_STANDBY, 10);
    s_auto    <= 1'b1;
    rst_pin_n <= 1'b0;
    ws(ST_RESET, 5);
    rst_pin_n <= 1'b1;
    ws(ST_NORMAL, 10);
    // managed slave does not wait in standby
    s_auto    <= 1'b0;
    s_master  <= 1'b0;
    rst_pin_n <= 1'b0;
    ws(ST_RESET, 5);
    rst_pin_n <= 1'b1;
    ws(ST_NORMAL, 10);
    chk("slave strap", {15'h0000, master}, 16'h0000);
    supply <= 1'b0;
    ws(ST_POWER_DOWN, 5);
    chk("off enables", en6, 16'h0000);
    results();
  end
endmodule // testbench
`default_nettype wire
